// [logic/asd_pkg.sv]
// Shared widths, operand/function/destination encodings and reset values of the ALU slice.
package asd_pkg;

	localparam int ASD_WIDTH = 16;
	localparam int ASD_DEPTH = 16;
	localparam int ASD_ADDR_W = 4;

	// ----------------------------------------------------------------
	// Field encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		src_a_and_q = 3'h0,
		src_a_and_b = 3'h1,
		src_zero_and_q = 3'h2,
		src_zero_and_b = 3'h3,
		src_zero_and_a = 3'h4,
		src_ext_and_a = 3'h5,
		src_ext_and_q = 3'h6,
		src_ext_and_zero = 3'h7
	} asd_src_t;

	typedef enum logic [2:0]
	{
		func_add = 3'h0,
		func_s_minus_r = 3'h1,
		func_r_minus_s = 3'h2,
		func_or = 3'h3,
		func_and = 3'h4,
		func_inv_r_and_s = 3'h5,
		func_xor = 3'h6,
		func_xnor = 3'h7
	} asd_func_t;

	typedef enum logic [2:0]
	{
		dest_load_q_only = 3'h0,
		dest_nop = 3'h1,
		dest_file_write_y_bypass = 3'h2,
		dest_file_write = 3'h3,
		dest_both_shift_down = 3'h4,
		dest_file_shift_down = 3'h5,
		dest_both_shift_up = 3'h6,
		dest_file_shift_up = 3'h7
	} asd_dest_t;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] ASD_WORD_RST = 16'h0000;
	localparam logic [2:0] ASD_SRC_RST = 3'h0;
	localparam logic [2:0] ASD_FUNC_RST = 3'h0;
	localparam logic [2:0] ASD_DEST_RST = 3'h1;
	localparam logic ASD_OE_N_RST = 1'b1;

endpackage

// [logic/asd_regfile.sv]
// Two-read, one-write register file with registered read data and write-first forwarding.
module asd_regfile #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int ADDR_W = 4
)
(
	input wire logic ref_clk_i,
	input wire logic [ADDR_W-1:0] rd_addr_a_i,
	input wire logic [ADDR_W-1:0] rd_addr_b_i,
	input wire logic wr_en_i,
	input wire logic [ADDR_W-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	output logic [WIDTH-1:0] rd_data_a_o,
	output logic [WIDTH-1:0] rd_data_b_o
);

	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge ref_clk_i)
	begin
		if (wr_en_i)
		begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end

	// Write-first: a read of the word being written sees the new value,
	// so back-to-back read-modify-write on one word needs no stall
	always_ff @(posedge ref_clk_i)
	begin
		rd_data_a_o <= (wr_en_i && wr_addr_i == rd_addr_a_i) ? wr_data_i : mem_q[rd_addr_a_i];
		rd_data_b_o <= (wr_en_i && wr_addr_i == rd_addr_b_i) ? wr_data_i : mem_q[rd_addr_b_i];
	end

endmodule

// [logic/asd_top.sv]
// Sixteen-bit microprogrammed ALU slice: operand select, ALU, shifters, Q register and status.
//
// Contract
// - Source field picks R and S operands
// - Function field picks one of eight operations
// - Add gives R plus S plus carry
// - S minus R adds inverted R, carry
// - R minus S adds inverted S, carry
// - Logic functions ignore the carry input
// - Add status: carry, overflow, lookahead P, G
// - Subtract status uses complemented subtrahend bits
// - Destinations 0, 2, 3: Q or file loads; 1 loads nothing
// - Destinations 4 to 7: shifted file; 4 and 6 also shift Q
// - Result bus shows A port for code 2
// - Shift pins carry edge bits between slices
// - Operands held while file writes at B
// - Open-drain zero detect plus separate sign output
module asd_top
	import asd_pkg::*;
#(
	parameter int WIDTH = ASD_WIDTH,
	parameter int DEPTH = ASD_DEPTH,
	parameter int ADDR_W = ASD_ADDR_W
)
(
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic [ADDR_W-1:0] addr_a_i,
	input wire logic [ADDR_W-1:0] addr_b_i,
	input wire logic [2:0] source_select_field_i,
	input wire logic [2:0] function_select_field_i,
	input wire logic [2:0] destination_select_field_i,
	input wire logic [WIDTH-1:0] data_i,
	input wire logic carry_in_i,
	input wire logic oe_n_i,
	input wire logic file_shift_low_pin_i,
	output logic file_shift_low_pin_o,
	output logic file_shift_low_pin_oe_n_o,
	input wire logic file_shift_high_pin_i,
	output logic file_shift_high_pin_o,
	output logic file_shift_high_pin_oe_n_o,
	input wire logic qshift_low_pin_i,
	output logic qshift_low_pin_o,
	output logic qshift_low_pin_oe_n_o,
	input wire logic qshift_high_pin_i,
	output logic qshift_high_pin_o,
	output logic qshift_high_pin_oe_n_o,
	output logic [WIDTH-1:0] y_o,
	output logic y_oe_n_o,
	output logic carry_out_o,
	output logic gen_n_o,
	output logic prop_n_o,
	output logic overflow_out_o,
	output logic result_sign_out_o,
	output logic zero_o,
	output logic zero_oe_n_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [WIDTH:0] asd_add(input logic [WIDTH-1:0] a, input logic [WIDTH-1:0] b,
		input logic c);
		return {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, c};
	endfunction

	// ----------------------------------------------------------------
	// Operand stage: instruction captured with the file read
	// ----------------------------------------------------------------
	asd_src_t src_q;
	asd_func_t func_q;
	asd_dest_t dest_q;
	logic [WIDTH-1:0] d_q;
	logic cin_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [WIDTH-1:0] rd_a;
	logic [WIDTH-1:0] rd_b;
	logic [WIDTH-1:0] q_q;

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			src_q <= asd_src_t'(ASD_SRC_RST);
			func_q <= asd_func_t'(ASD_FUNC_RST);
			dest_q <= asd_dest_t'(ASD_DEST_RST);
			d_q <= ASD_WORD_RST;
			cin_q <= 1'b0;
			wr_addr_q <= '0;
		end
		else
		begin
			src_q <= asd_src_t'(source_select_field_i);
			func_q <= asd_func_t'(function_select_field_i);
			dest_q <= asd_dest_t'(destination_select_field_i);
			d_q <= data_i;
			cin_q <= carry_in_i;
			wr_addr_q <= addr_b_i;
		end
	end

	// ----------------------------------------------------------------
	// ALU
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] r_op;
	logic [WIDTH-1:0] s_op;
	logic [WIDTH-1:0] r_eff;
	logic [WIDTH-1:0] s_eff;
	logic [WIDTH:0] sum_full;
	logic [WIDTH:0] sum_low;
	logic [WIDTH:0] gen_chain;
	logic [WIDTH-1:0] f;
	logic arith;
	logic c_out;
	logic overflow_out;
	logic p_n;
	logic g_n;

	always_comb
	begin
		unique case (src_q)
			src_a_and_q: begin r_op = rd_a; s_op = q_q; end
			src_a_and_b: begin r_op = rd_a; s_op = rd_b; end
			src_zero_and_q: begin r_op = '0; s_op = q_q; end
			src_zero_and_b: begin r_op = '0; s_op = rd_b; end
			src_zero_and_a: begin r_op = '0; s_op = rd_a; end
			src_ext_and_a: begin r_op = d_q; s_op = rd_a; end
			src_ext_and_q: begin r_op = d_q; s_op = q_q; end
			src_ext_and_zero: begin r_op = d_q; s_op = '0; end
		endcase
	end

	always_comb
	begin
		// One's complement of the subtrahend; cin supplies the +1
		r_eff = (func_q == func_s_minus_r) ? ~r_op : r_op;
		s_eff = (func_q == func_r_minus_s) ? ~s_op : s_op;
		sum_full = asd_add(r_eff, s_eff, cin_q);
		sum_low = asd_add({1'b0, r_eff[WIDTH-2:0]}, {1'b0, s_eff[WIDTH-2:0]}, cin_q);
		// Group generate equals the carry out with no carry in
		gen_chain = asd_add(r_eff, s_eff, 1'b0);
		arith = (func_q == func_add) || (func_q == func_s_minus_r) || (func_q == func_r_minus_s);
		unique case (func_q)
			func_add: f = sum_full[WIDTH-1:0];
			func_s_minus_r: f = sum_full[WIDTH-1:0];
			func_r_minus_s: f = sum_full[WIDTH-1:0];
			func_or: f = r_op | s_op;
			func_and: f = r_op & s_op;
			func_inv_r_and_s: f = ~r_op & s_op;
			func_xor: f = r_op ^ s_op;
			func_xnor: f = ~(r_op ^ s_op);
		endcase
		c_out = arith & sum_full[WIDTH];
		overflow_out = arith & (sum_full[WIDTH] ^ sum_low[WIDTH-1]);
		p_n = ~(arith & (&(r_eff | s_eff)));
		g_n = ~(arith & gen_chain[WIDTH]);
	end

	// ----------------------------------------------------------------
	// Destination and shifters
	// ----------------------------------------------------------------
	logic file_we;
	logic [WIDTH-1:0] file_wd;
	logic q_we;
	logic [WIDTH-1:0] q_d;

	always_comb
	begin
		file_we = 1'b0;
		file_wd = f;
		q_we = 1'b0;
		q_d = f;
		unique case (dest_q)
			dest_load_q_only: q_we = 1'b1;
			dest_nop: file_we = 1'b0;
			dest_file_write_y_bypass: file_we = 1'b1;
			dest_file_write: file_we = 1'b1;
			dest_both_shift_down:
			begin
				file_we = 1'b1;
				file_wd = {file_shift_high_pin_i, f[WIDTH-1:1]};
				q_we = 1'b1;
				q_d = {qshift_high_pin_i, q_q[WIDTH-1:1]};
			end
			dest_file_shift_down:
			begin
				file_we = 1'b1;
				file_wd = {file_shift_high_pin_i, f[WIDTH-1:1]};
			end
			dest_both_shift_up:
			begin
				file_we = 1'b1;
				file_wd = {f[WIDTH-2:0], file_shift_low_pin_i};
				q_we = 1'b1;
				q_d = {q_q[WIDTH-2:0], qshift_low_pin_i};
			end
			dest_file_shift_up:
			begin
				file_we = 1'b1;
				file_wd = {f[WIDTH-2:0], file_shift_low_pin_i};
			end
		endcase
	end

	// Operands come from registered read data, so the write at B below
	// cannot disturb the values the ALU is working on this cycle
	asd_regfile #(
		.WIDTH(WIDTH),
		.DEPTH(DEPTH),
		.ADDR_W(ADDR_W)
	) u_file (
		.ref_clk_i(ref_clk_i),
		.rd_addr_a_i(addr_a_i),
		.rd_addr_b_i(addr_b_i),
		.wr_en_i(file_we),
		.wr_addr_i(wr_addr_q),
		.wr_data_i(file_wd),
		.rd_data_a_o(rd_a),
		.rd_data_b_o(rd_b)
	);

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			q_q <= ASD_WORD_RST;
		end
		else if (q_we)
		begin
			q_q <= q_d;
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			y_o <= ASD_WORD_RST;
			carry_out_o <= 1'b0;
			gen_n_o <= 1'b1;
			prop_n_o <= 1'b1;
			overflow_out_o <= 1'b0;
			result_sign_out_o <= 1'b0;
			zero_o <= 1'b0;
			zero_oe_n_o <= 1'b1;
		end
		else
		begin
			y_o <= (dest_q == dest_file_write_y_bypass) ? rd_a : f;
			carry_out_o <= c_out;
			gen_n_o <= g_n;
			prop_n_o <= p_n;
			overflow_out_o <= overflow_out;
			result_sign_out_o <= f[WIDTH-1];
			// Open drain: pull low only while the result is non-zero
			zero_o <= 1'b0;
			zero_oe_n_o <= (f == '0);
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			y_oe_n_o <= ASD_OE_N_RST;
		end
		else
		begin
			y_oe_n_o <= oe_n_i;
		end
	end

	// Shift pins turn round with the destination code; a cascaded neighbour
	// sees our edge bit one cycle after the shift that produced it
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			file_shift_low_pin_o <= 1'b0;
			file_shift_low_pin_oe_n_o <= 1'b1;
			file_shift_high_pin_o <= 1'b0;
			file_shift_high_pin_oe_n_o <= 1'b1;
			qshift_low_pin_o <= 1'b0;
			qshift_low_pin_oe_n_o <= 1'b1;
			qshift_high_pin_o <= 1'b0;
			qshift_high_pin_oe_n_o <= 1'b1;
		end
		else
		begin
			file_shift_low_pin_o <= f[0];
			file_shift_low_pin_oe_n_o <= ~(dest_q == dest_both_shift_down || dest_q == dest_file_shift_down);
			file_shift_high_pin_o <= f[WIDTH-1];
			file_shift_high_pin_oe_n_o <= ~(dest_q == dest_both_shift_up || dest_q == dest_file_shift_up);
			qshift_low_pin_o <= q_q[0];
			qshift_low_pin_oe_n_o <= ~(dest_q == dest_both_shift_down || dest_q == dest_file_shift_down);
			qshift_high_pin_o <= q_q[WIDTH-1];
			qshift_high_pin_oe_n_o <= ~(dest_q == dest_both_shift_up || dest_q == dest_file_shift_up);
		end
	end

endmodule

// [sim/asd_assertions.sv]
// Port-level checks of the ALU slice, each output tied to the instruction taken two edges before, the result enable to the request one edge before.
module asd_assertions
	import asd_pkg::*;
#(
	parameter int WIDTH = ASD_WIDTH
)
(
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic [2:0] source_select_field_i,
	input wire logic [2:0] function_select_field_i,
	input wire logic [2:0] destination_select_field_i,
	input wire logic [WIDTH-1:0] data_i,
	input wire logic carry_in_i,
	input wire logic oe_n_i,
	input wire logic [WIDTH-1:0] y_o,
	input wire logic y_oe_n_o,
	input wire logic carry_out_o,
	input wire logic gen_n_o,
	input wire logic prop_n_o,
	input wire logic overflow_out_o,
	input wire logic result_sign_out_o,
	input wire logic zero_o,
	input wire logic zero_oe_n_o,
	input wire logic file_shift_low_pin_o,
	input wire logic file_shift_low_pin_oe_n_o
);
	// ----------------------------------------------------------------
	// Instruction history
	// ----------------------------------------------------------------
	// The first output after release comes from the reset instruction, not a taken one, so checks wait for a clean history
	logic [1:0] rst_q;
	logic [5:0] src_q, func_q, dest_q;
	logic [2*WIDTH-1:0] data_q;
	logic [1:0] cin_q;
	logic fy;
	always_ff @(posedge ref_clk_i)
	begin
		rst_q <= {rst_q[0], srst_i};
		src_q <= {src_q[2:0], source_select_field_i};
		func_q <= {func_q[2:0], function_select_field_i};
		dest_q <= {dest_q[2:0], destination_select_field_i};
		data_q <= {data_q[WIDTH-1:0], data_i};
		cin_q <= {cin_q[0], carry_in_i};
	end
	assign fy = rst_q == 2'h0 && dest_q[5:3] != 3'h2;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (srst_i);
	property p_oe;
		!rst_q[0] |-> y_oe_n_o == $past(oe_n_i);
	endproperty
	a_oe: assert property (p_oe) else $error("result enable does not follow request");
	property p_zero;
		fy |-> !zero_o && zero_oe_n_o == (y_o == '0);
	endproperty
	a_zero: assert property (p_zero) else $error("zero detect wrong");
	property p_sign;
		fy |-> result_sign_out_o == y_o[WIDTH-1];
	endproperty
	a_sign: assert property (p_sign) else $error("sign output wrong");
	property p_logic;
		rst_q == 2'h0 && func_q[5:3] >= 3'h3 |-> gen_n_o && prop_n_o && !carry_out_o && !overflow_out_o;
	endproperty
	a_logic: assert property (p_logic) else $error("logic status flags wrong");
	property p_add_ext;
		fy && func_q[5:3] == 3'h0 && src_q[5:3] == 3'h7 |-> y_o == data_q[2*WIDTH-1:WIDTH] + cin_q[1];
	endproperty
	a_add_ext: assert property (p_add_ext) else $error("add of external operand wrong");
	property p_func_s_minus_r_ext;
		fy && func_q[5:3] == 3'h1 && src_q[5:3] == 3'h7 |-> y_o == ~data_q[2*WIDTH-1:WIDTH] + cin_q[1];
	endproperty
	a_func_s_minus_r_ext: assert property (p_func_s_minus_r_ext) else $error("reverse subtract wrong");
	property p_and_zero;
		fy && func_q[5:3] == 3'h4 && src_q[5:3] inside {3'h2, 3'h3, 3'h4, 3'h7} |-> y_o == '0;
	endproperty
	a_and_zero: assert property (p_and_zero) else $error("and with zero operand not zero");
	property p_down_pin;
		rst_q == 2'h0 && dest_q[5:4] == 2'b10 |-> !file_shift_low_pin_oe_n_o && file_shift_low_pin_o == y_o[0];
	endproperty
	a_down_pin: assert property (p_down_pin) else $error("down shift low pin wrong");
endmodule
bind asd_top asd_assertions #(.WIDTH(WIDTH)) u_asd_assertions (.ref_clk_i, .srst_i, .source_select_field_i,
	.function_select_field_i, .destination_select_field_i, .data_i, .carry_in_i, .oe_n_i, .y_o, .y_oe_n_o,
	.carry_out_o, .gen_n_o, .prop_n_o, .overflow_out_o, .result_sign_out_o, .zero_o, .zero_oe_n_o,
	.file_shift_low_pin_o, .file_shift_low_pin_oe_n_o);

// [sim/asd_ctrl_model.sv]
// Controller stand-in: presents one instruction per call and supplies the neighbour's cascade bits.
module asd_ctrl_model
	import asd_pkg::*;
(
	input wire logic ref_clk_i,
	output logic [3:0] addr_a_o,
	output logic [3:0] addr_b_o,
	output logic [2:0] src_o,
	output logic [2:0] func_o,
	output logic [2:0] dest_o,
	output logic [15:0] data_o,
	output logic carry_o,
	output logic oe_n_o,
	output logic [3:0] shift_in_o
);
	initial
	begin
		{addr_a_o, addr_b_o, src_o, func_o, data_o, carry_o, shift_in_o} = '0;
		// The first word taken after reset reads no file word: the file holds nothing defined yet
		src_o = src_ext_and_zero;
		dest_o = dest_nop;
		oe_n_o = 1'b1;
	end
	// Fields change at the falling edge only, so the rising edge sees them settled
	task automatic issue(input logic [2:0] s, f, d, input logic [3:0] a, b, input logic [15:0] dd, input logic c);
		@(negedge ref_clk_i);
		{src_o, func_o, dest_o, addr_a_o, addr_b_o, data_o, carry_o} = {s, f, d, a, b, dd, c};
	endtask
	// Cascade bits: file high, file low, q high, q low; held until changed
	task automatic set_side(input logic oe, input logic [3:0] sh);
		oe_n_o = oe;
		shift_in_o = sh;
	endtask
endmodule

// [sim/test_alu_slice_16bit_datapath.sv]
// Self-checking bench of the ALU slice, driven through the controller stand-in.
module test_alu_slice_16bit_datapath;
	timeunit 1ns;
	timeprecision 1ps;
	import asd_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] aa, ab, sh, pin_o, pin_oe, pin_i;
	logic [2:0] src, fn, dst;
	logic [15:0] dat, y, q_m;
	logic [15:0] file_m [16];
	logic cin, oe_n, y_oe_n, cout, gen_n, prop_n, ovf, sign, zero, zero_oe_n;
	int num_errors = 0;
	int n_checks = 0;
	always #12.5 clk = ~clk;
	// A cascade wire shows this slice's bit while it drives, the neighbour's otherwise
	assign pin_i = (pin_o & ~pin_oe) | (sh & pin_oe);
	asd_ctrl_model ctl (.ref_clk_i(clk), .addr_a_o(aa), .addr_b_o(ab), .src_o(src), .func_o(fn), .dest_o(dst),
		.data_o(dat), .carry_o(cin), .oe_n_o(oe_n), .shift_in_o(sh));
	asd_top dut (.ref_clk_i(clk), .srst_i(srst), .addr_a_i(aa), .addr_b_i(ab), .source_select_field_i(src),
		.function_select_field_i(fn), .destination_select_field_i(dst), .data_i(dat), .carry_in_i(cin),
		.oe_n_i(oe_n), .file_shift_low_pin_i(pin_i[2]), .file_shift_low_pin_o(pin_o[2]),
		.file_shift_low_pin_oe_n_o(pin_oe[2]), .file_shift_high_pin_i(pin_i[3]), .file_shift_high_pin_o(pin_o[3]),
		.file_shift_high_pin_oe_n_o(pin_oe[3]), .qshift_low_pin_i(pin_i[0]), .qshift_low_pin_o(pin_o[0]),
		.qshift_low_pin_oe_n_o(pin_oe[0]), .qshift_high_pin_i(pin_i[1]), .qshift_high_pin_o(pin_o[1]),
		.qshift_high_pin_oe_n_o(pin_oe[1]), .y_o(y), .y_oe_n_o(y_oe_n), .carry_out_o(cout), .gen_n_o(gen_n),
		.prop_n_o(prop_n), .overflow_out_o(ovf), .result_sign_out_o(sign), .zero_o(zero), .zero_oe_n_o(zero_oe_n));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One instruction then a no-op; results are judged one edge after the instruction is taken
	task automatic run(input logic [2:0] s, f, d, input logic [3:0] a, b, input logic [15:0] dd, input logic c);
		logic [15:0] r, sv, rr, ss, fx, lo;
		logic [16:0] sum, g;
		r = (s <= 3'h1) ? file_m[a] : (s <= 3'h4) ? 16'h0 : dd;
		case (s)
			3'h0, 3'h2, 3'h6: sv = q_m;
			3'h1, 3'h3: sv = file_m[b];
			3'h4, 3'h5: sv = file_m[a];
			default: sv = 16'h0;
		endcase
		rr = (f == 3'h1) ? ~r : r;
		ss = (f == 3'h2) ? ~sv : sv;
		sum = {1'b0, rr} + {1'b0, ss} + {16'h0, c};
		g = {1'b0, rr} + {1'b0, ss};
		lo = {1'b0, rr[14:0]} + {1'b0, ss[14:0]} + {15'h0, c};
		case (f)
			3'h3: fx = r | sv;
			3'h4: fx = r & sv;
			3'h5: fx = ~r & sv;
			3'h6: fx = r ^ sv;
			3'h7: fx = ~(r ^ sv);
			default: fx = sum[15:0];
		endcase
		ctl.issue(s, f, d, a, b, dd, c);
		ctl.issue(3'h0, 3'h0, dest_nop, 4'h0, 4'h0, 16'h0, 1'b0);
		@(negedge clk);
		chk(y, (d == 3'h2) ? file_m[a] : fx);
		chk({zero, zero_oe_n, sign, y_oe_n}, {1'b0, fx == 16'h0, fx[15], oe_n});
		chk(pin_oe, {~d[2] | ~d[1], ~d[2] | d[1], ~d[2] | ~d[1], ~d[2] | d[1]});
		if (d[2:1] == 2'b10)
			chk(pin_o[2], fx[0]);
		chk({cout, ovf, gen_n, prop_n}, (f <= 3'h2) ? {sum[16], sum[16] ^ lo[15], ~g[16], ~&(rr | ss)} : 4'h3);
		if (d == 3'h4)
			chk({pin_oe[0], pin_o[0]}, {1'b0, q_m[0]});
		if (d[2:1] == 2'b11)
			chk({pin_oe[3], pin_o[3], pin_oe[1], pin_o[1]}, {1'b0, fx[15], 1'b0, q_m[15]});
		case (d)
			3'h0: q_m = fx;
			3'h2, 3'h3: file_m[b] = fx;
			3'h4, 3'h5: file_m[b] = {sh[3], fx[15:1]};
			3'h6, 3'h7: file_m[b] = {fx[14:0], sh[2]};
			default: ;
		endcase
		if (d == 3'h4)
			q_m = {sh[1], q_m[15:1]};
		if (d == 3'h6)
			q_m = {q_m[14:0], sh[0]};
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_load();
		for (int i = 0; i < 16; i++)
			run(3'h7, 3'h3, 3'h3, 4'h0, i[3:0], 16'h1111 * i[15:0] ^ 16'h8421, 1'b0);
		run(3'h7, 3'h3, 3'h0, 4'h0, 4'h0, 16'h8001, 1'b0);
	endtask
	// Every source with every function and both carries; the external word forces an overflow
	task automatic t_matrix();
		for (int k = 0; k < 128; k++)
			run(k[2:0], k[5:3], dest_nop, 4'h3, 4'h7, 16'h7ffe, k[6]);
	endtask
	// Read-modify-write of one word through every destination, Q read back after each
	task automatic t_dest();
		ctl.set_side(1'b1, 4'b1010);
		for (int k = 0; k < 16; k++)
		begin
			if (k == 8)
				ctl.set_side(1'b1, 4'b0101);
			run(3'h1, 3'h0, k[2:0], 4'h5, 4'h5, 16'h0, k[0]);
			run(3'h2, 3'h3, dest_nop, 4'h0, 4'h0, 16'h0, 1'b0);
		end
	endtask
	task automatic t_oe();
		ctl.set_side(1'b0, 4'h0);
		run(3'h5, 3'h0, dest_file_write_y_bypass, 4'h9, 4'h2, 16'h0101, 1'b1);
		ctl.set_side(1'b1, 4'h0);
		run(3'h5, 3'h0, dest_file_write, 4'h9, 4'h2, 16'h0101, 1'b1);
	endtask
	initial
	begin
		repeat (3) @(negedge clk);
		srst = 1'b0;
		t_load();
		t_matrix();
		t_dest();
		t_oe();
		end_sim();
	end
	// About 600 cycles are needed; 4000 cycles means a hang
	initial
	begin
		#100us;
		num_errors++;
		end_sim();
	end
endmodule
